// ### design/dil_fifo.sv
// Parameterised FIFO with a registered read word.
`timescale 1ns/1ps
`default_nettype none

module dil_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    // ==========================================================
    // Storage and pointers
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [PW:0]      next_count;
    logic [WIDTH-1:0] next_out_data;
    logic             push;
    logic             pop;

    assign in_ready  = (count != DEPTH[PW:0]);
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ==========================================================
    // Next state
    // The head word is kept in a register, so a write into the slot
    // that becomes the head in the same cycle is forwarded directly.
    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
        if (push && (next_rd_ptr == wr_ptr)) begin
            next_out_data = in_data;
        end else begin
            next_out_data = mem[next_rd_ptr];
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
        out_data <= next_out_data;
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

endmodule : dil_fifo

`default_nettype wire

// ### design/dil_pkg.sv
// Shared constants for the converter input latch control block.
package dil_pkg;

    // ==========================================================
    // Sample word layout
    localparam int          SAMPLE_W   = 8;
    localparam int          LSB_POS    = 0;
    localparam int          MSB_POS    = 7;
    localparam logic [7:0]  CODE_MAX   = 8'hff;
    localparam logic [7:0]  CODE_MID   = 8'h80;
    localparam logic [7:0]  CODE_MIN   = 8'h00;
    localparam logic [7:0]  RESET_CODE = 8'h00;

    // ==========================================================
    // Output current weights, in steps of full scale over 256
    localparam int          WEIGHT_W   = 9;
    localparam logic [8:0]  FULL_SCALE = 9'h100;
    localparam logic [8:0]  HALF_SCALE = 9'h080;
    localparam logic [8:0]  ZERO_SCALE = 9'h000;

    // ==========================================================
    // Input buffer
    localparam int          FIFO_DEPTH = 16;

    // ==========================================================
    // Timing
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          PIPE_LATENCY  = 1;

endpackage : dil_pkg

// ### design/dil_top.sv
// Input latch, standby and reference control of the 8-bit converter.
`timescale 1ns/1ps
`default_nettype none

module dil_top (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] sample_in,
    input  wire logic       sample_valid,
    output logic            sample_ready,
    input  wire logic       standby_request_pin,
    input  wire logic       standby_pin_driven,
    input  wire logic       ref_select_external,
    output logic      [7:0] latched_code,
    output logic      [8:0] true_current_output,
    output logic      [8:0] complement_current_output,
    output logic            in_standby,
    output logic            internal_ref_enable,
    output logic            reference_pin_input_mode
);

    // ==========================================================
    // Code to current weights

    // Full scale is 256 steps, so code 255 must map to the whole of
    // it for the all-ones case to leave nothing on the complement.
    function automatic logic [8:0] true_weight(input logic [7:0] code);
        logic [8:0] w;
        w = {1'b0, code};
        if (code == dil_pkg::CODE_MAX) begin
            w = dil_pkg::FULL_SCALE;
        end
        return w;
    endfunction : true_weight

    function automatic logic [8:0] comp_weight(input logic [7:0] code);
        return dil_pkg::FULL_SCALE - true_weight(code);
    endfunction : comp_weight

    // ==========================================================
    // Declarations
    logic       standby_level;
    logic       fifo_valid;
    logic       fifo_pop;
    logic [7:0] fifo_data;
    logic [7:0] master_code;
    logic [7:0] next_master_code;
    logic [7:0] next_latched_code;
    logic [8:0] next_true_current;
    logic [8:0] next_comp_current;
    logic       next_in_standby;
    logic       next_internal_ref;
    logic       next_ref_input;

    // ==========================================================
    // Input buffer
    dil_fifo #(
        .WIDTH (dil_pkg::SAMPLE_W),
        .DEPTH (dil_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   (sample_in),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // ==========================================================
    // Control pins

    // An undriven pin reads low, standing in for the internal pull-down.
    assign standby_level = standby_request_pin && standby_pin_driven;

    // While in standby the buffer is not drained, so it fills and the
    // source is stalled through its ready.
    assign fifo_pop = fifo_valid && !standby_level;

    // ==========================================================
    // Next values of the latch pipeline
    always_comb begin
        next_master_code  = master_code;
        next_latched_code = latched_code;
        if (!standby_level) begin
            if (fifo_pop) begin
                next_master_code = fifo_data;
            end
            next_latched_code = master_code;
        end
        next_in_standby = standby_level;
        next_true_current = dil_pkg::ZERO_SCALE;
        next_comp_current = dil_pkg::ZERO_SCALE;
        if (!standby_level) begin
            next_true_current = true_weight(next_latched_code);
            next_comp_current = comp_weight(next_latched_code);
        end
        next_internal_ref = !ref_select_external;
        next_ref_input    = ref_select_external;
    end

    // ==========================================================
    // Registers

    // Codes are cleared only by reset; standby leaves them untouched.
    always_ff @(posedge clk) begin
        if (reset) begin
            master_code               <= dil_pkg::RESET_CODE;
            latched_code              <= dil_pkg::RESET_CODE;
            true_current_output       <= dil_pkg::ZERO_SCALE;
            complement_current_output <= dil_pkg::FULL_SCALE;
            in_standby                <= 1'b0;
            internal_ref_enable       <= 1'b1;
            reference_pin_input_mode  <= 1'b0;
        end else begin
            master_code               <= next_master_code;
            latched_code              <= next_latched_code;
            true_current_output       <= next_true_current;
            complement_current_output <= next_comp_current;
            in_standby                <= next_in_standby;
            internal_ref_enable       <= next_internal_ref;
            reference_pin_input_mode  <= next_ref_input;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking

    default disable iff (reset);

    a_capture_head_word: assert property (
        fifo_pop |=> master_code == $past(fifo_data)
    ) else $error("master stage missed the head word");

    a_bit_order_kept: assert property (
        fifo_pop |=> master_code[dil_pkg::MSB_POS] ==
            $past(fifo_data[dil_pkg::MSB_POS]) &&
            master_code[dil_pkg::LSB_POS] ==
            $past(fifo_data[dil_pkg::LSB_POS])
    ) else $error("sample bit order changed");

    a_one_cycle_latency: assert property (
        (fifo_pop ##1 !standby_level) |=>
            latched_code == $past(fifo_data, 2)
    ) else $error("latched code not one edge after capture");

    a_not_early_output: assert property (
        (fifo_pop && fifo_data != latched_code &&
            fifo_data != master_code) |=>
            latched_code != $past(fifo_data)
    ) else $error("latched code appeared with no pipeline delay");

    a_full_scale_true: assert property (
        (!in_standby && latched_code == dil_pkg::CODE_MAX) |->
            true_current_output == dil_pkg::FULL_SCALE &&
            complement_current_output == dil_pkg::ZERO_SCALE
    ) else $error("all ones code not full scale on true output");

    a_mid_code_split: assert property (
        (!in_standby && latched_code == dil_pkg::CODE_MID) |->
            true_current_output == dil_pkg::HALF_SCALE &&
            complement_current_output == dil_pkg::HALF_SCALE
    ) else $error("mid code does not split current equally");

    a_zero_code_comp: assert property (
        (!in_standby && latched_code == dil_pkg::CODE_MIN) |->
            true_current_output == dil_pkg::ZERO_SCALE &&
            complement_current_output == dil_pkg::FULL_SCALE
    ) else $error("zero code not full scale on complement");

    a_standby_quiet: assert property (
        standby_level |=> in_standby &&
            true_current_output == dil_pkg::ZERO_SCALE &&
            complement_current_output == dil_pkg::ZERO_SCALE
    ) else $error("standby did not stop the outputs");

    a_standby_no_drain: assert property (
        standby_level |-> !fifo_pop
    ) else $error("buffer drained during standby");

    a_pulldown_default: assert property (
        !standby_pin_driven [*2] |-> !in_standby
    ) else $error("undriven standby pin did not read low");

    a_internal_ref_sel: assert property (
        !ref_select_external |=>
            internal_ref_enable && !reference_pin_input_mode
    ) else $error("internal reference not selected");

    a_external_ref_sel: assert property (
        ref_select_external |=>
            !internal_ref_enable && reference_pin_input_mode
    ) else $error("external reference not selected");

    a_codes_held: assert property (
        standby_level |=> $stable(master_code) && $stable(latched_code)
    ) else $error("latched codes changed during standby");

    a_resume_last_code: assert property (
        (in_standby ##1 !in_standby) |->
            latched_code == $past(master_code) &&
            true_current_output == true_weight(latched_code)
    ) else $error("resume did not present the last latched code");

endmodule : dil_top

`default_nettype wire

// ### dv/dil_source_model.sv
// Sample source model that feeds words into the converter latch.
`timescale 1ns/1ps
`default_nettype none

module dil_source_model (
    input  wire logic       clk,
    input  wire logic       sample_ready,
    output logic            sample_valid,
    output logic      [7:0] sample_in
);
    // ==========================================================
    // Word driver
    logic       ok;
    logic [7:0] last_word;

    initial begin
        sample_valid = 1'b0;
        sample_in    = 8'h00;
        ok           = 1'b1;
        last_word    = 8'h00;
    end

    // Valid and data are held until an edge sees ready high.
    task automatic send(input logic [7:0] w);
        int i;
        sample_valid <= 1'b1;
        sample_in    <= w;
        last_word    = w;
        for (i = 0; i < 64; i++) begin
            @(posedge clk);
            if (sample_ready === 1'b1) break;
        end
        ok = (i < 64);
    endtask : send

    // An idle bus shows the inverse of the last word, not a stale copy.
    task automatic idle();
        sample_valid <= 1'b0;
        sample_in    <= ~last_word;
    endtask : idle
endmodule : dil_source_model
`default_nettype wire

// ### dv/dil_top_test.sv
// Self-checking testbench for the converter input latch control block.
`timescale 1ns/1ps
`default_nettype none

module dil_top_test;
    // ==========================================================
    // Clock, reset and design
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       standby_request_pin = 1'b0;
    logic       standby_pin_driven = 1'b0;
    logic       ref_select_external = 1'b0;
    logic [7:0] sample_in, latched_code;
    logic       sample_valid, sample_ready, in_standby;
    logic [8:0] true_current_output, complement_current_output;
    logic       internal_ref_enable, reference_pin_input_mode;
    int         mismatches = 0;
    int         n_compared = 0;

    always #12.5 clk = ~clk;

    dil_top dut_u (
        .clk                       (clk),
        .reset                     (reset),
        .sample_in                 (sample_in),
        .sample_valid              (sample_valid),
        .sample_ready              (sample_ready),
        .standby_request_pin       (standby_request_pin),
        .standby_pin_driven        (standby_pin_driven),
        .ref_select_external       (ref_select_external),
        .latched_code              (latched_code),
        .true_current_output       (true_current_output),
        .complement_current_output (complement_current_output),
        .in_standby                (in_standby),
        .internal_ref_enable       (internal_ref_enable),
        .reference_pin_input_mode  (reference_pin_input_mode)
    );

    dil_source_model src_u (
        .clk          (clk),
        .sample_ready (sample_ready),
        .sample_valid (sample_valid),
        .sample_in    (sample_in)
    );

    // ==========================================================
    // Shared tasks
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [8:0] exp,
                       input logic [8:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic tx(input logic [7:0] w);
        src_u.send(w);
        if (!src_u.ok) begin
            mismatches++;
            $display("MISMATCH accept expected 1 seen 0");
            results();
        end
    endtask : tx

    task automatic chk_out(input logic [7:0] c, input logic [8:0] t,
                           input logic [8:0] k);
        chk("latched_code", {1'b0, c}, {1'b0, latched_code});
        chk("true_current", t, true_current_output);
        chk("comp_current", k, complement_current_output);
    endtask : chk_out

    // ==========================================================
    // Table of codes and expected currents
    typedef struct packed {
        logic [7:0] code;
        logic [8:0] t;
        logic [8:0] k;
    } dil_row_t;
    // 8'hfe and 8'h01 expose any reversal of the bit order.
    dil_row_t rows [7] = '{
        '{8'h00, 9'h000, 9'h100}, '{8'h01, 9'h001, 9'h0ff},
        '{8'h7f, 9'h07f, 9'h081}, '{8'h80, 9'h080, 9'h080},
        '{8'hfe, 9'h0fe, 9'h002}, '{8'hff, 9'h100, 9'h000},
        '{8'ha5, 9'h0a5, 9'h05b}};

    initial begin
        int i;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 7; i++) begin
            tx(rows[i].code);
            src_u.idle();
            repeat (2) @(posedge clk);
            #1;
            chk_out(rows[i].code, rows[i].t, rows[i].k);
            @(posedge clk);
        end
        $display("code table done");
        // Floating standby pin reads low, then a driven high enters standby.
        @(posedge clk);
        standby_request_pin <= 1'b1;
        @(posedge clk);
        #1;
        chk("standby_float", 9'h000, {8'h00, in_standby});
        @(posedge clk);
        standby_pin_driven <= 1'b1;
        @(posedge clk);
        #1;
        chk("standby_on", 9'h001, {8'h00, in_standby});
        chk_out(8'ha5, 9'h000, 9'h000);
        // The buffer is not drained in standby, so it fills and refuses.
        @(posedge clk);
        for (i = 0; i < 16; i++) tx(8'h10 + 8'(i));
        src_u.idle();
        #1;
        chk("ready_full", 9'h000, {8'h00, sample_ready});
        @(posedge clk);
        standby_request_pin <= 1'b0;
        @(posedge clk);
        #1;
        chk("standby_off", 9'h000, {8'h00, in_standby});
        chk_out(8'ha5, 9'h0a5, 9'h05b);
        for (i = 0; i < 8 && latched_code !== 8'h10; i++) begin
            @(posedge clk);
            #1;
        end
        chk("drain_first", 9'h010, {1'b0, latched_code});
        for (i = 1; i < 16; i++) begin
            @(posedge clk);
            #1;
            chk("drain", 9'h010 + 9'(i), {1'b0, latched_code});
        end
        $display("standby and buffer done");
        @(posedge clk);
        ref_select_external <= 1'b1;
        @(posedge clk);
        #1;
        chk("int_ref_ext", 9'h000, {8'h00, internal_ref_enable});
        chk("pin_in_ext", 9'h001, {8'h00, reference_pin_input_mode});
        @(posedge clk);
        ref_select_external <= 1'b0;
        @(posedge clk);
        #1;
        chk("int_ref_int", 9'h001, {8'h00, internal_ref_enable});
        chk("pin_in_int", 9'h000, {8'h00, reference_pin_input_mode});
        $display("reference select done");
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk_out(8'h00, 9'h000, 9'h100);
        chk("rst_standby", 9'h000, {8'h00, in_standby});
        chk("rst_int_ref", 9'h001, {8'h00, internal_ref_enable});
        chk("rst_pin_in", 9'h000, {8'h00, reference_pin_input_mode});
        chk("rst_ready", 9'h001, {8'h00, sample_ready});
        // A word sent right after a mid-run release must pass normally.
        @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        tx(8'h3c);
        src_u.idle();
        repeat (2) @(posedge clk);
        #1;
        chk_out(8'h3c, 9'h03c, 9'h0c4);
        $display("reset done");
        results();
    end
endmodule : dil_top_test
`default_nettype wire
